// ### etc_pkg.sv
package etc_pkg;

  // bus geometry
  localparam int unsigned ETC_AW = 3;
  localparam int unsigned ETC_DW = 8;

  // register offsets
  localparam logic [2:0] ETC_OFF_CTRL_A = 3'h0;
  localparam logic [2:0] ETC_OFF_CTRL_B = 3'h1;
  localparam logic [2:0] ETC_OFF_COUNT = 3'h2;
  localparam logic [2:0] ETC_OFF_CMP_A = 3'h3;
  localparam logic [2:0] ETC_OFF_CMP_B = 3'h4;
  localparam logic [2:0] ETC_OFF_FLAG = 3'h5;
  localparam logic [2:0] ETC_OFF_MASK = 3'h6;

  // timer_control_a fields
  localparam int unsigned ETC_CA_COMA_LO = 6;
  localparam int unsigned ETC_CA_COMB_LO = 4;
  localparam int unsigned ETC_CA_WGM_LO = 0;
  localparam logic [7:0] ETC_CA_MASK = 8'hf3;

  // timer_control_b fields
  localparam int unsigned ETC_CB_FOCA = 7;
  localparam int unsigned ETC_CB_FOCB = 6;
  localparam int unsigned ETC_CB_WGM2 = 3;
  localparam int unsigned ETC_CB_CS_LO = 0;
  localparam logic [7:0] ETC_CB_MASK = 8'h0f;

  // flag and mask bit positions
  localparam int unsigned ETC_FL_OVF = 0;
  localparam int unsigned ETC_FL_MA = 1;
  localparam int unsigned ETC_FL_MB = 2;
  localparam int unsigned ETC_FL_W = 3;

  // counter values
  localparam logic [7:0] ETC_BOTTOM = 8'h00;
  localparam logic [7:0] ETC_MAX = 8'hff;
  localparam logic [7:0] ETC_ONE = 8'h01;
  localparam logic [7:0] ETC_RST8 = 8'h00;
  localparam logic [2:0] ETC_RST3 = 3'h0;
  localparam logic [7:0] ETC_RD_NONE = 8'h00;

  // prescaler taps
  localparam int unsigned ETC_PRE_W = 10;
  localparam logic [9:0] ETC_PRE_RST = 10'h000;
  localparam logic [9:0] ETC_PRE_INC = 10'h001;
  localparam logic [9:0] ETC_PRE_M8 = 10'h007;
  localparam logic [9:0] ETC_PRE_M64 = 10'h03f;
  localparam logic [9:0] ETC_PRE_M256 = 10'h0ff;
  localparam logic [9:0] ETC_PRE_M1024 = 10'h3ff;

  typedef enum logic [2:0] {
    ETC_CS_OFF = 3'b000,
    ETC_CS_DIV1 = 3'b001,
    ETC_CS_DIV8 = 3'b010,
    ETC_CS_DIV64 = 3'b011,
    ETC_CS_DIV256 = 3'b100,
    ETC_CS_DIV1024 = 3'b101,
    ETC_CS_EXT_FALL = 3'b110,
    ETC_CS_EXT_RISE = 3'b111
  } etc_cs_t;

  typedef enum logic [2:0] {
    ETC_WGM_NORMAL = 3'b000,
    ETC_WGM_PC_MAX = 3'b001,
    ETC_WGM_CTC = 3'b010,
    ETC_WGM_FAST_MAX = 3'b011,
    ETC_WGM_RSV4 = 3'b100,
    ETC_WGM_PC_CMPA = 3'b101,
    ETC_WGM_RSV6 = 3'b110,
    ETC_WGM_FAST_CMPA = 3'b111
  } etc_wgm_t;

  typedef enum logic [1:0] {
    ETC_COM_OFF = 2'b00,
    ETC_COM_TOGGLE = 2'b01,
    ETC_COM_CLEAR = 2'b10,
    ETC_COM_SET = 2'b11
  } etc_com_t;

endpackage

// ### etc_timer.sv
// Overview of operation
// RULE1: counter and both compare registers 8 bits
// RULE2: tick from prescaler or external pin
// RULE3: clock select picks source and edge
// RULE4: select zero gives no tick, counter stopped
// RULE5: bottom indication when counter is zero
// RULE6: maximum is 0xFF, signalled when reached
// RULE7: top is 0xFF or compare A per mode
// RULE8: each tick clears, increments or decrements
// RULE9: counter readable and writable at any time
// RULE10: cpu counter write beats tick update
// RULE11: three-bit mode split across both controls
// RULE12: overflow flag set per mode, interrupt source
// RULE13: continuous equality compare per unit
// RULE14: match sets flag on following tick
// RULE15: servicing the interrupt clears its flag
// RULE16: writing one clears flag, zero keeps
// RULE17: three flags in one register, masked separately
// RULE18: waveform from match, mode, output mode
// RULE19: max and bottom handle extreme values
// RULE20: buffer stage in front of compares
// RULE21: buffer only in pwm, else direct write
// RULE22: counter write blocks next tick's match
// RULE23: normal mode counts up, overflow at wrap
// RULE24: reset clears counter, compares, flags, mask
`timescale 1ns/1ps
module etc_timer
  import etc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [etc_pkg::ETC_AW-1:0] reg_addr,
  input wire logic [etc_pkg::ETC_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [etc_pkg::ETC_DW-1:0] reg_rdata,
  // external count source
  input wire logic ext_count_pin,
  // interrupt requests and service acknowledges
  output logic irq_ovf,
  output logic irq_a,
  output logic irq_b,
  input wire logic irq_ack_ovf,
  input wire logic irq_ack_a,
  input wire logic irq_ack_b,
  // waveform outputs
  output logic wave_out_a,
  output logic wave_en_a,
  output logic wave_out_b,
  output logic wave_en_b
);
  import etc_pkg::*;

  // state
  logic [7:0] timer_control_a_q;
  logic [7:0] timer_control_b_q;
  logic [7:0] count_value_q, count_value_d;
  logic [7:0] compare_value_a_q, compare_value_a_d;
  logic [7:0] compare_value_b_q, compare_value_b_d;
  logic [7:0] buf_a_q;
  logic [7:0] buf_b_q;
  logic [ETC_FL_W-1:0] timer_flag_reg_q, timer_flag_reg_d;
  logic [ETC_FL_W-1:0] timer_mask_reg_q;
  logic [ETC_PRE_W-1:0] pre_q;
  logic ext_prev_q;
  logic down_q, down_d;
  logic block_q;
  logic wave_a_q, wave_a_d;
  logic wave_b_q, wave_b_d;
  logic [7:0] rdata_q;

  // register decode
  wire wr_ctrl_a = reg_wr && (reg_addr == ETC_OFF_CTRL_A);
  wire wr_ctrl_b = reg_wr && (reg_addr == ETC_OFF_CTRL_B);
  wire wr_count = reg_wr && (reg_addr == ETC_OFF_COUNT);
  wire wr_cmp_a = reg_wr && (reg_addr == ETC_OFF_CMP_A);
  wire wr_cmp_b = reg_wr && (reg_addr == ETC_OFF_CMP_B);
  wire wr_flag = reg_wr && (reg_addr == ETC_OFF_FLAG);
  wire wr_mask = reg_wr && (reg_addr == ETC_OFF_MASK);

  // mode fields
  etc_wgm_t waveform_mode_field;
  etc_cs_t clock_select_field;
  etc_com_t compare_output_mode_a;
  etc_com_t compare_output_mode_b;
  wire waveform_mode_bit2 = timer_control_b_q[ETC_CB_WGM2];
  wire [1:0] waveform_mode_lo = timer_control_a_q[ETC_CA_WGM_LO +: 2];

  assign waveform_mode_field = etc_wgm_t'({waveform_mode_bit2, waveform_mode_lo}); // [RULE11]
  assign clock_select_field = etc_cs_t'(timer_control_b_q[ETC_CB_CS_LO +: 3]);
  assign compare_output_mode_a = etc_com_t'(timer_control_a_q[ETC_CA_COMA_LO +: 2]);
  assign compare_output_mode_b = etc_com_t'(timer_control_a_q[ETC_CA_COMB_LO +: 2]);

  wire is_pc = (waveform_mode_field == ETC_WGM_PC_MAX) ||
               (waveform_mode_field == ETC_WGM_PC_CMPA);
  wire is_fast = (waveform_mode_field == ETC_WGM_FAST_MAX) ||
                 (waveform_mode_field == ETC_WGM_FAST_CMPA);
  wire is_pwm = is_pc || is_fast;
  wire top_from_a = (waveform_mode_field == ETC_WGM_CTC) ||
                    (waveform_mode_field == ETC_WGM_PC_CMPA) ||
                    (waveform_mode_field == ETC_WGM_FAST_CMPA);

  // count sequence limits
  wire [7:0] top_value = top_from_a ? compare_value_a_q : ETC_MAX; // [RULE7]
  wire at_top = (count_value_q == top_value);
  wire at_bottom = (count_value_q == ETC_BOTTOM); // [RULE5]
  wire at_max = (count_value_q == ETC_MAX); // [RULE6]
  wire [7:0] count_inc = count_value_q + ETC_ONE;
  wire [7:0] count_dec = count_value_q - ETC_ONE;

  // comparators run every cycle, whatever the tick does
  wire match_a = (count_value_q == compare_value_a_q); // [RULE13]
  wire match_b = (count_value_q == compare_value_b_q); // [RULE13]

  // prescaler and clock select
  wire [ETC_PRE_W-1:0] pre_d = pre_q + ETC_PRE_INC;
  logic timer_tick;

  always_comb begin
    unique case (clock_select_field) // [RULE3]
      ETC_CS_OFF: timer_tick = 1'b0; // [RULE4]
      ETC_CS_DIV1: timer_tick = 1'b1; // [RULE2]
      ETC_CS_DIV8: timer_tick = ((pre_q & ETC_PRE_M8) == ETC_PRE_M8);
      ETC_CS_DIV64: timer_tick = ((pre_q & ETC_PRE_M64) == ETC_PRE_M64);
      ETC_CS_DIV256: timer_tick = ((pre_q & ETC_PRE_M256) == ETC_PRE_M256);
      ETC_CS_DIV1024: timer_tick = (pre_q == ETC_PRE_M1024);
      ETC_CS_EXT_FALL: timer_tick = ext_prev_q && !ext_count_pin; // [RULE2]
      ETC_CS_EXT_RISE: timer_tick = !ext_prev_q && ext_count_pin; // [RULE2]
    endcase
  end

  // a tick that loses to a cpu write counts as no event
  wire ev = timer_tick && !wr_count;

  // counter next value
  always_comb begin
    count_value_d = count_value_q;
    down_d = is_pc ? down_q : 1'b0;
    if (wr_count) begin
      count_value_d = reg_wdata; // [RULE9] [RULE10]
    end else if (timer_tick) begin // [RULE8]
      if (is_pc) begin
        if (!down_q) begin
          if (at_top) begin
            down_d = 1'b1;
            count_value_d = count_dec;
          end else begin
            count_value_d = count_inc;
          end
        end else begin
          if (at_bottom) begin
            down_d = 1'b0;
            count_value_d = count_inc;
          end else begin
            count_value_d = count_dec;
          end
        end
      end else if (at_top) begin
        count_value_d = ETC_BOTTOM; // [RULE23]
      end else begin
        count_value_d = count_inc;
      end
    end
  end

  // overflow point by mode
  logic ovf_set;

  always_comb begin
    unique case (waveform_mode_field) // [RULE12]
      ETC_WGM_NORMAL: ovf_set = ev && at_max; // [RULE23]
      ETC_WGM_CTC: ovf_set = ev && at_max;
      ETC_WGM_RSV4: ovf_set = ev && at_max;
      ETC_WGM_RSV6: ovf_set = ev && at_max;
      ETC_WGM_FAST_MAX: ovf_set = ev && at_top;
      ETC_WGM_FAST_CMPA: ovf_set = ev && at_top;
      ETC_WGM_PC_MAX: ovf_set = ev && down_q && at_bottom;
      ETC_WGM_PC_CMPA: ovf_set = ev && down_q && at_bottom;
    endcase
  end

  // match events: flagged on the tick after equality, unless blocked
  wire mset_a = ev && match_a && !block_q; // [RULE14] [RULE22]
  wire mset_b = ev && match_b && !block_q; // [RULE14] [RULE22]

  // flags: hardware set wins over any clear in the same cycle
  wire [ETC_FL_W-1:0] flag_set = {mset_b, mset_a, ovf_set};
  wire [ETC_FL_W-1:0] flag_wclr = wr_flag ? reg_wdata[ETC_FL_W-1:0] : ETC_RST3; // [RULE16]
  wire [ETC_FL_W-1:0] flag_ack = {irq_ack_b, irq_ack_a, irq_ack_ovf}; // [RULE15]
  assign timer_flag_reg_d = (timer_flag_reg_q & ~(flag_wclr | flag_ack)) | flag_set;

  assign irq_ovf = timer_flag_reg_q[ETC_FL_OVF] && timer_mask_reg_q[ETC_FL_OVF]; // [RULE17]
  assign irq_a = timer_flag_reg_q[ETC_FL_MA] && timer_mask_reg_q[ETC_FL_MA]; // [RULE17]
  assign irq_b = timer_flag_reg_q[ETC_FL_MB] && timer_mask_reg_q[ETC_FL_MB]; // [RULE17]

  // compare buffers: pwm updates land at top so no odd-length pulse appears
  wire cmp_update = ev && at_top && (is_fast || (is_pc && !down_q)); // [RULE21]

  always_comb begin
    compare_value_a_d = compare_value_a_q;
    if (wr_cmp_a && !is_pwm) begin
      compare_value_a_d = reg_wdata; // [RULE21]
    end else if (cmp_update) begin
      compare_value_a_d = buf_a_q; // [RULE20]
    end
  end

  always_comb begin
    compare_value_b_d = compare_value_b_q;
    if (wr_cmp_b && !is_pwm) begin
      compare_value_b_d = reg_wdata; // [RULE21]
    end else if (cmp_update) begin
      compare_value_b_d = buf_b_q; // [RULE20]
    end
  end

  // waveform generator
  function automatic logic wave_next(
    input logic cur,
    input etc_com_t com,
    input logic hit,
    input logic pc,
    input logic fast,
    input logic bot,
    input logic down,
    input logic full,
    input logic zero,
    input logic tog_ok
  );
    logic inv;
    logic nxt;
    inv = (com == ETC_COM_SET);
    nxt = cur;
    if (!pc && !fast) begin
      if (hit) begin
        unique case (com)
          ETC_COM_OFF: nxt = cur;
          ETC_COM_TOGGLE: nxt = !cur;
          ETC_COM_CLEAR: nxt = 1'b0;
          ETC_COM_SET: nxt = 1'b1;
        endcase
      end
    end else if (com == ETC_COM_TOGGLE) begin
      if (hit && tog_ok) begin
        nxt = !cur;
      end
    end else if (com != ETC_COM_OFF) begin
      if (fast) begin
        if (bot) begin
          nxt = !inv;
        end
        // compare at top would clear in the tick that sets: keep it set
        if (hit && !full) begin
          nxt = inv;
        end
      end else begin
        if (hit) begin
          nxt = down ? !inv : inv;
        end
        // compare at bottom holds the inactive level for the whole period
        if (bot && zero) begin
          nxt = inv;
        end
      end
    end
    return nxt;
  endfunction

  // forced compare only acts outside pwm, and never touches flags or counter
  wire force_a = wr_ctrl_b && reg_wdata[ETC_CB_FOCA] && !is_pwm;
  wire force_b = wr_ctrl_b && reg_wdata[ETC_CB_FOCB] && !is_pwm;
  wire wave_bot = is_fast ? (ev && at_top) : (ev && down_q && at_bottom); // [RULE19]
  wire full_a = (compare_value_a_q == top_value); // [RULE19]
  wire full_b = (compare_value_b_q == top_value); // [RULE19]
  wire zero_a = (compare_value_a_q == ETC_BOTTOM); // [RULE19]
  wire zero_b = (compare_value_b_q == ETC_BOTTOM); // [RULE19]

  assign wave_a_d = wave_next(wave_a_q, compare_output_mode_a, mset_a || force_a, // [RULE18]
    is_pc, is_fast, wave_bot, down_q, full_a, zero_a, waveform_mode_bit2);
  assign wave_b_d = wave_next(wave_b_q, compare_output_mode_b, mset_b || force_b, // [RULE18]
    is_pc, is_fast, wave_bot, down_q, full_b, zero_b, 1'b0);

  assign wave_out_a = wave_a_q;
  assign wave_out_b = wave_b_q;
  assign wave_en_a = (compare_output_mode_a != ETC_COM_OFF);
  assign wave_en_b = (compare_output_mode_b != ETC_COM_OFF);

  // read mux; the cpu sees the buffer side of each compare
  logic [7:0] rd_mux;

  always_comb begin
    case (reg_addr)
      ETC_OFF_CTRL_A: rd_mux = timer_control_a_q;
      ETC_OFF_CTRL_B: rd_mux = timer_control_b_q;
      ETC_OFF_COUNT: rd_mux = count_value_q; // [RULE9]
      ETC_OFF_CMP_A: rd_mux = buf_a_q;
      ETC_OFF_CMP_B: rd_mux = buf_b_q;
      ETC_OFF_FLAG: rd_mux = {5'h0_0, timer_flag_reg_q}; // [RULE17]
      ETC_OFF_MASK: rd_mux = {5'h0_0, timer_mask_reg_q};
      default: rd_mux = ETC_RD_NONE;
    endcase
  end

  assign reg_rdata = rdata_q;

  // control and bus registers
  always_ff @(posedge clk) begin
    if (reset) begin
      timer_control_a_q <= ETC_RST8; // [RULE24]
      timer_control_b_q <= ETC_RST8; // [RULE24]
      timer_mask_reg_q <= ETC_RST3; // [RULE24]
      rdata_q <= ETC_RD_NONE;
    end else begin
      if (wr_ctrl_a) timer_control_a_q <= reg_wdata & ETC_CA_MASK;
      if (wr_ctrl_b) timer_control_b_q <= reg_wdata & ETC_CB_MASK;
      if (wr_mask) timer_mask_reg_q <= reg_wdata[ETC_FL_W-1:0];
      rdata_q <= reg_rd ? rd_mux : ETC_RD_NONE;
    end
  end

  // counter, compares and buffers
  always_ff @(posedge clk) begin
    if (reset) begin
      count_value_q <= ETC_RST8; // [RULE24]
      compare_value_a_q <= ETC_RST8; // [RULE24]
      compare_value_b_q <= ETC_RST8;
      buf_a_q <= ETC_RST8;
      buf_b_q <= ETC_RST8;
      down_q <= 1'b0;
    end else begin
      count_value_q <= count_value_d; // [RULE1]
      compare_value_a_q <= compare_value_a_d; // [RULE1]
      compare_value_b_q <= compare_value_b_d;
      if (wr_cmp_a) buf_a_q <= reg_wdata; // [RULE20]
      if (wr_cmp_b) buf_b_q <= reg_wdata;
      down_q <= down_d;
    end
  end

  // flags and match blocking
  always_ff @(posedge clk) begin
    if (reset) begin
      timer_flag_reg_q <= ETC_RST3; // [RULE24]
      block_q <= 1'b0;
    end else begin
      timer_flag_reg_q <= timer_flag_reg_d;
      // held until a later tick, so a stopped timer still blocks
      if (wr_count) block_q <= 1'b1; // [RULE22]
      else if (timer_tick) block_q <= 1'b0;
    end
  end

  // prescaler and pin history; pin rests low so no false edge after reset
  always_ff @(posedge clk) begin
    if (reset) begin
      pre_q <= ETC_PRE_RST;
      ext_prev_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      ext_prev_q <= ext_count_pin;
    end
  end

  // waveform state survives mode changes
  always_ff @(posedge clk) begin
    if (reset) begin
      wave_a_q <= 1'b0;
      wave_b_q <= 1'b0;
    end else begin
      wave_a_q <= wave_a_d;
      wave_b_q <= wave_b_d;
    end
  end

endmodule

// ### etc_ext_src.sv
`timescale 1ns/1ps
module etc_ext_src (
  // clock
  input wire logic clk,
  // request
  input wire logic start,
  input wire logic [7:0] n_pulses,
  input wire logic [3:0] half,
  // pin and status
  output logic pin,
  output logic done
);
  logic [8:0] left_q;
  logic [3:0] cnt_q;
  // pin rests low between bursts, so no stray edge when a source is selected
  initial begin
    pin = 1'b0;
    done = 1'b1;
    left_q = 9'h000;
    cnt_q = 4'h0;
  end
  always @(posedge clk) begin
    if (start) begin
      left_q <= {n_pulses, 1'b0};
      cnt_q <= half;
      done <= 1'b0;
    end else if (left_q != 9'h000) begin
      if (cnt_q == 4'h0) begin
        pin <= ~pin;
        left_q <= left_q - 9'h001;
        cnt_q <= half;
      end else begin
        cnt_q <= cnt_q - 4'h1;
      end
    end else begin
      done <= 1'b1;
    end
  end
endmodule

// ### etc_timer_assertions.sv
`timescale 1ns/1ps
module etc_timer_chk
  import etc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [etc_pkg::ETC_AW-1:0] reg_addr,
  input wire logic [etc_pkg::ETC_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [etc_pkg::ETC_DW-1:0] reg_rdata,
  // external count source
  input wire logic ext_count_pin,
  // interrupts
  input wire logic irq_ovf,
  input wire logic irq_a,
  input wire logic irq_b,
  input wire logic irq_ack_ovf,
  input wire logic irq_ack_a,
  input wire logic irq_ack_b,
  // waveform outputs
  input wire logic wave_out_a,
  input wire logic wave_en_a,
  input wire logic wave_out_b,
  input wire logic wave_en_b
);
  logic [7:0] wd_q;
  logic [7:0] wd_qq;
  // write data kept two deep to judge a read that follows a write
  always_ff @(posedge clk) begin
    wd_q <= reg_wdata;
    wd_qq <= wd_q;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == ETC_RD_NONE)
    else $error("read data not zero outside answer");
  unmapped_read_a: assert property ($past(reg_rd) && $past(reg_addr) == 3'h7
    |-> reg_rdata == ETC_RD_NONE) else $error("unmapped read not zero");
  flag_width_a: assert property (reg_rd && reg_addr == ETC_OFF_FLAG
    |=> reg_rdata[7:3] == 5'h00) else $error("flag register spare bits set");
  mask_gate_a: assert property (reg_wr && reg_addr == ETC_OFF_MASK && reg_wdata == 8'h00
    |=> !irq_ovf && !irq_a && !irq_b) else $error("masked request visible");
  reset_quiet_a: assert property ($past(reset) |-> !irq_ovf && !irq_a && !irq_b &&
    !wave_en_a && !wave_en_b && !wave_out_a && !wave_out_b) else $error("not quiet after reset");
  pin_en_a: assert property (reg_wr && reg_addr == ETC_OFF_CTRL_A
    |=> wave_en_a == (wd_q[7:6] != 2'b00)) else $error("unit a enable wrong");
  pin_en_b_a: assert property (reg_wr && reg_addr == ETC_OFF_CTRL_A
    |=> wave_en_b == (wd_q[5:4] != 2'b00)) else $error("unit b enable wrong");
  count_back_a: assert property (reg_wr && reg_addr == ETC_OFF_COUNT ##1
    reg_rd && reg_addr == ETC_OFF_COUNT |=> reg_rdata == wd_qq) else $error("count write lost");
  cmp_back_a: assert property (reg_wr && reg_addr == ETC_OFF_CMP_A ##1
    reg_rd && reg_addr == ETC_OFF_CMP_A |=> reg_rdata == wd_qq) else $error("compare write lost");
  ctrl_back_a: assert property (reg_wr && reg_addr == ETC_OFF_CTRL_A ##1
    reg_rd && reg_addr == ETC_OFF_CTRL_A |=> reg_rdata == (wd_qq & ETC_CA_MASK))
    else $error("control a readback wrong");
endmodule
bind etc_timer etc_timer_chk u_chk (.clk(clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ext_count_pin(ext_count_pin), .irq_ovf(irq_ovf), .irq_a(irq_a), .irq_b(irq_b),
  .irq_ack_ovf(irq_ack_ovf), .irq_ack_a(irq_ack_a), .irq_ack_b(irq_ack_b),
  .wave_out_a(wave_out_a), .wave_en_a(wave_en_a), .wave_out_b(wave_out_b),
  .wave_en_b(wave_en_b));

// ### tb.sv
`timescale 1ns/1ps
module tb;
  import etc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic ext_count_pin, irq_ovf, irq_a, irq_b, src_done;
  logic wave_out_a, wave_en_a, wave_out_b, wave_en_b;
  logic [2:0] ack = 3'h0;
  logic src_go = 1'b0;
  logic [3:0] src_half = 4'h1;
  logic rd_seen = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] d;
  int n_fail = 0;
  int checks = 0;
  int tn = 0;
  int seed = 32'h0000_e572;
  int dv[5] = '{1, 8, 64, 256, 1024};
  logic [7:0] xs[3] = '{8'h00, 8'h06, 8'h07};
  logic [7:0] ev[3] = '{8'h00, 8'h05, 8'h05};
  etc_timer dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_count_pin(ext_count_pin),
    .irq_ovf(irq_ovf), .irq_a(irq_a), .irq_b(irq_b), .irq_ack_ovf(ack[0]),
    .irq_ack_a(ack[1]), .irq_ack_b(ack[2]), .wave_out_a(wave_out_a),
    .wave_en_a(wave_en_a), .wave_out_b(wave_out_b), .wave_en_b(wave_en_b));
  etc_ext_src src (.clk(clk), .start(src_go), .n_pulses(8'h05), .half(src_half),
    .pin(ext_count_pin), .done(src_done));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // every bus call owns one cycle, so strobes are never assigned twice per step
  task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [7:0] v);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    bus(1'b1, 1'b0, a, v);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 3'h0, 8'h00);
  endtask
  // clock runs for exactly n cycles between the two control writes
  task automatic run(input logic [2:0] cs, input int n);
    wr(ETC_OFF_CTRL_B, {5'h00, cs});
    idle(n - 1);
    wr(ETC_OFF_CTRL_B, 8'h00);
  endtask
  task automatic pins(input logic [7:0] e);
    idle(1);
    @(negedge clk);
    check({3'h0, wave_out_b, wave_out_a, irq_b, irq_a, irq_ovf}, e);
    @(posedge clk);
  endtask
  task automatic tdone;
    tn++;
    $display("test %0d done", tn);
  endtask
  always @(negedge clk) begin
    if (rd_seen) check(reg_rdata, exp_q.pop_front());
    rd_seen = reg_rd;
  end
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
    tdone();
    for (int k = 0; k < 6; k++) begin
      d = 8'($random(seed));
      wr(ETC_OFF_CTRL_A, d);
      rd(ETC_OFF_CTRL_A, d & ETC_CA_MASK);
      wr(ETC_OFF_COUNT, d);
      rd(ETC_OFF_COUNT, d);
      wr(ETC_OFF_CMP_A, ~d);
      rd(ETC_OFF_CMP_A, ~d);
      wr(3'h7, d);
      rd(3'h7, 8'h00);
    end
    wr(ETC_OFF_CTRL_A, 8'h00);
    wr(ETC_OFF_COUNT, 8'h5a);
    idle(20);
    rd(ETC_OFF_COUNT, 8'h5a);
    tdone();
    wr(ETC_OFF_CMP_A, 8'h10);
    wr(ETC_OFF_CMP_B, 8'h30);
    wr(ETC_OFF_FLAG, 8'h07);
    wr(ETC_OFF_COUNT, 8'hfe);
    run(3'h1, 2);
    rd(ETC_OFF_COUNT, 8'h00);
    rd(ETC_OFF_FLAG, 8'h01);
    wr(ETC_OFF_FLAG, 8'h07);
    wr(ETC_OFF_CTRL_A, 8'h40);
    wr(ETC_OFF_COUNT, 8'h0f);
    run(3'h1, 1);
    rd(ETC_OFF_FLAG, 8'h00);
    run(3'h1, 1);
    rd(ETC_OFF_FLAG, 8'h02);
    wr(ETC_OFF_FLAG, 8'h00);
    rd(ETC_OFF_FLAG, 8'h02);
    pins(8'h08);
    tdone();
    wr(ETC_OFF_MASK, 8'h00);
    pins(8'h08);
    wr(ETC_OFF_MASK, 8'h07);
    rd(ETC_OFF_MASK, 8'h07);
    pins(8'h0a);
    ack <= 3'h7;
    idle(1);
    ack <= 3'h0;
    pins(8'h08);
    wr(ETC_OFF_COUNT, 8'h10);
    run(3'h1, 1);
    rd(ETC_OFF_FLAG, 8'h00);
    wr(ETC_OFF_CTRL_B, 8'h01);
    idle(3);
    wr(ETC_OFF_COUNT, 8'h40);
    wr(ETC_OFF_CTRL_B, 8'h00);
    rd(ETC_OFF_COUNT, 8'h41);
    tdone();
    for (int k = 0; k < 5; k++) begin
      wr(ETC_OFF_COUNT, 8'h00);
      run(3'(k + 1), 2 * dv[k]);
      rd(ETC_OFF_COUNT, 8'h02);
    end
    for (int k = 0; k < 3; k++) begin
      wr(ETC_OFF_COUNT, 8'h00);
      wr(ETC_OFF_CTRL_B, xs[k]);
      src_half <= 4'(1 + 3 * k);
      src_go <= 1'b1;
      idle(1);
      src_go <= 1'b0;
      // let the source's busy state settle before polling it
      idle(1);
      for (int i = 0; i < 300 && src_done !== 1'b1; i++) @(posedge clk);
      if (src_done !== 1'b1) begin
        n_fail++;
        close_out();
      end
      wr(ETC_OFF_CTRL_B, 8'h00);
      rd(ETC_OFF_COUNT, ev[k]);
    end
    tdone();
    wr(ETC_OFF_CTRL_A, 8'h02);
    wr(ETC_OFF_CMP_A, 8'h03);
    wr(ETC_OFF_COUNT, 8'h00);
    run(3'h1, 5);
    rd(ETC_OFF_COUNT, 8'h01);
    wr(ETC_OFF_CTRL_A, 8'h01);
    wr(ETC_OFF_COUNT, 8'hfe);
    run(3'h1, 3);
    rd(ETC_OFF_COUNT, 8'hfd);
    wr(ETC_OFF_COUNT, 8'h01);
    run(3'h1, 2);
    rd(ETC_OFF_FLAG, 8'h03);
    tdone();
    // force is ignored in pwm and acts in normal mode
    wr(ETC_OFF_FLAG, 8'h07);
    wr(ETC_OFF_CTRL_A, 8'h31);
    wr(ETC_OFF_CTRL_B, 8'h40);
    pins(8'h08);
    wr(ETC_OFF_CTRL_A, 8'h30);
    wr(ETC_OFF_CTRL_B, 8'h40);
    pins(8'h18);
    // fast pwm: old compare acts until the wrap loads the buffer
    wr(ETC_OFF_CTRL_A, 8'hc3);
    wr(ETC_OFF_COUNT, 8'h02);
    wr(ETC_OFF_CMP_A, 8'h02);
    rd(ETC_OFF_CMP_A, 8'h02);
    run(3'h1, 255);
    pins(8'h17);
    run(3'h1, 2);
    pins(8'h1f);
    ack <= 3'h1;
    idle(1);
    ack <= 3'h0;
    pins(8'h1e);
    idle(2);
    tdone();
    close_out();
  end
endmodule
